//--- inc/baud_clock_pkg.sv
// Package: constants and types for the bit-rate clock selection block
`default_nettype none
package baud_clock_pkg;

  // ==========================================================
  // Field positions and divide ratios
  localparam int BYPASS_BIT        = 5;  // channel_config_second
  localparam int CFG2_HI_LSB       = 6;  // bits 7..6 = N/m high pair
  localparam int ENHANCED_BIT      = 6;  // channel_config_fourth
  localparam int QUARTER_BIT       = 7;  // channel_config_fourth
  localparam int DPLL_DIV          = 16;
  localparam int QUARTER_DIV       = 4;

  // ==========================================================
  // Command completion time, in slow-clock periods times ten
  localparam int CMD_TIME_X10      = 25;
  localparam logic [2:0] CMD_EDGES = 3'(( CMD_TIME_X10 + 9 ) / 10);

  // ==========================================================
  // Reset values
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;

  // ==========================================================
  // Clock modes
  typedef enum logic [1:0] {
    MODE_EXT_ONLY,
    MODE_DIV_TX_OUT,
    MODE_DIV_RX_PIN,
    MODE_DPLL
  } clock_mode_e;

  typedef enum logic [1:0] {
    FMT_ASYNC,
    FMT_HDLC,
    FMT_BISYNC
  } frame_format_e;

  // ==========================================================
  // Per-channel configuration
  typedef struct packed {
    logic [7:0]    channel_config_second;
    logic [7:0]    channel_config_fourth;
    logic [7:0]    baud_divisor_reg;
    logic          async_oversample_select;
    clock_mode_e   mode;
    frame_format_e format;
    logic          master_clock_enable;
    logic          tx_out_switch;
  } chan_cfg_s;

endpackage : baud_clock_pkg
`default_nettype wire

//--- hdl/serial_baud_clock_select.sv
// Design: bit-rate divider and clock source selection, one channel
// Function
// R1 - Bypass flag bit 5 gives divisor 1, else (N+1)*2
// R2 - N is config2 bits 7..6 shifted above the eight divisor bits
// R3 - Enhanced mode divisor is (n+1)*2^m from divisor and config bits
// R4 - Enhanced mode with m zero gives an uneven duty cycle
// R5 - Standard mode: divisor low six bits zero forces N to zero
// R6 - Without recovery, bit rate is input clock over divisor
// R7 - DPLL modes in HDLC or bisync add a divide by 16
// R8 - Far end uses DPLL modes only up to 2 MHz
// R9 - Oversampling select applies only to asynchronous format
// R10 - Outside master-clock mode, internal timing follows transmit clock
// R11 - Commands take up to 2.5 internal clocks; host waits for done
// R12 - Far end should use master clock below 1 MHz or gated clocks
// R13 - Oscillator stays below 10 MHz in master mode unless quartered
// R14 - Config4 bit 7 makes master clock oscillator divided by four
// R15 - External receive to transmit clock ratio stays below 3 or 1.5
// R16 - One oscillator feeds both channels; divisors stay independent
// R17 - Mode 0a takes receive and transmit timing from external pins
// R18 - Mode 0b with switch set drives divided clock on timing output
// R19 - Clock mode selects divider input: oscillator or receive pin
// R20 - Far end should supply frequent data edges for recovery
// R21 - Config4 bit 6 enables the enhanced divider
// R22 - Master clock at least 2.5 times transmit clock
// R23 - Oscillator programmed through board port value bits 0 and 1
`default_nettype none
module serial_baud_clock_select
  import baud_clock_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      oscillator_input,
  input  wire logic      receive_timing_in,
  input  wire logic      send_timing_in,
  input  wire chan_cfg_s cfg,
  input  wire logic      command_register_wr,
  output logic           transmit_timing_out,
  output logic           transmit_timing_oe_n,
  output logic           rx_bit_clock,
  output logic           tx_bit_clock,
  output logic           internal_timing,
  output logic           command_busy,
  output logic           sample_x16
);

  // ==========================================================
  // Divisor decode
  wire logic [9:0]  n_std;
  wire logic [9:0]  n_eff;
  wire logic [5:0]  n_enh;
  wire logic [3:0]  m_enh;
  wire logic        bypass;
  wire logic        enhanced;
  wire logic [10:0] half_std;
  wire logic [21:0] half_enh;
  wire logic [21:0] half_cnt;
  wire logic        odd_split;

  assign bypass   = cfg.channel_config_second[BYPASS_BIT];
  assign enhanced = cfg.channel_config_fourth[ENHANCED_BIT]; // [R21]
  assign n_std = {cfg.channel_config_second[7:CFG2_HI_LSB],
                  cfg.baud_divisor_reg};                      // [R2]
  assign n_eff = (cfg.baud_divisor_reg[5:0] == 6'h00) ? 10'h000
                 : n_std;                                     // [R5]
  assign n_enh = cfg.baud_divisor_reg[5:0];
  assign m_enh = {cfg.channel_config_second[7:CFG2_HI_LSB],
                  cfg.baud_divisor_reg[7:6]};                 // [R3]
  // Standard half period count, twice is the divisor; half_enh is the whole enhanced divisor
  assign half_std = 11'(n_eff) + 11'h001;                     // [R1]
  assign half_enh = (22'(n_enh) + 22'h000001) << m_enh;       // [R3]
  assign odd_split = enhanced && (m_enh == 4'h0);             // [R4]
  // m zero: high phase one edge, low phase n edges, n+1 in all
  assign half_cnt = enhanced ? (odd_split ? 22'(n_enh)
                                          : half_enh >> 1)
                             : 22'(half_std);

  // ==========================================================
  // Source selection and edge detection
  wire logic src_raw;
  wire logic mclk_src;
  wire logic osc_rise;
  logic      src_q;
  logic      src_edge_q;
  logic      osc_q;
  logic [1:0] quarter_q;

  assign src_raw = (cfg.mode == MODE_DIV_RX_PIN) ? receive_timing_in
                   : oscillator_input;                        // [R19] [R16]
  assign mclk_src = cfg.channel_config_fourth[QUARTER_BIT] ?
                    quarter_q[1] : oscillator_input;          // [R14]
  assign osc_rise = oscillator_input & ~osc_q;

  always_ff @(posedge clk)
  begin
    src_q      <= src_raw;
    src_edge_q <= src_raw & ~src_q;
    osc_q      <= oscillator_input;
  end

  // Four oscillator rising edges make one quarter-rate period
  always_ff @(posedge clk)
  begin
    if (rst)
      quarter_q <= 2'h0;
    else if (osc_rise)
      quarter_q <= quarter_q + 2'h1;                          // [R14]
  end

  // ==========================================================
  // Divider
  logic [21:0] cnt_q;
  logic        div_q;
  logic        div_edge_q;
  logic [3:0]  dpll_q;
  wire logic   use_dpll;
  wire logic [21:0] limit;

  assign limit = (odd_split && div_q) ? 22'h000001 : half_cnt; // [R4]

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q      <= 22'h0;
      div_q      <= 1'b0;
      div_edge_q <= 1'b0;
    end
    else if (bypass)
    begin
      // Divisor one: the output follows the source level
      cnt_q      <= 22'h0;
      div_q      <= src_q;                                    // [R1]
      div_edge_q <= src_edge_q;
    end
    else if (src_edge_q)
    begin
      if (cnt_q + 22'h1 >= limit)
      begin
        cnt_q      <= 22'h0;
        div_q      <= ~div_q;                                 // [R6]
        div_edge_q <= ~div_q;
      end
      else
      begin
        cnt_q      <= cnt_q + 22'h1;
        div_edge_q <= 1'b0;
      end
    end
    else
      div_edge_q <= 1'b0;
  end

  assign use_dpll = (cfg.mode == MODE_DPLL) &&
                    (cfg.format != FMT_ASYNC);

  always_ff @(posedge clk)
  begin
    if (rst)
      dpll_q <= 4'h0;
    else if (div_edge_q)
      dpll_q <= dpll_q + 4'h1;                                // [R7]
  end

  // ==========================================================
  // Outputs
  wire logic gen_clk;
  wire logic tx_sel;
  wire logic rx_sel;
  wire logic out_en;

  assign gen_clk = use_dpll ? dpll_q[3] : div_q;              // [R7]
  assign tx_sel = (cfg.mode == MODE_EXT_ONLY) ? send_timing_in
                  : gen_clk;                                  // [R17]
  assign rx_sel = (cfg.mode == MODE_EXT_ONLY ||
                   cfg.mode == MODE_DIV_TX_OUT) ? receive_timing_in
                  : gen_clk;                                  // [R17]
  assign out_en = (cfg.mode == MODE_DIV_TX_OUT) && cfg.tx_out_switch;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      transmit_timing_out  <= 1'b0;
      transmit_timing_oe_n <= 1'b1;
      rx_bit_clock         <= 1'b0;
      tx_bit_clock         <= 1'b0;
      sample_x16           <= 1'b0;
    end
    else
    begin
      transmit_timing_out  <= out_en & div_q;                 // [R18]
      transmit_timing_oe_n <= ~out_en;                        // [R18]
      rx_bit_clock         <= rx_sel;
      tx_bit_clock         <= tx_sel;
      sample_x16 <= (cfg.format == FMT_ASYNC) &
                    cfg.async_oversample_select;              // [R9]
    end
  end

  // ==========================================================
  // Internal timing and command completion
  wire logic timing_src;
  logic      timing_q;
  logic      timing_edge_q;
  logic [2:0] cmd_cnt_q;

  assign timing_src = cfg.master_clock_enable ? mclk_src
                      : tx_sel;                               // [R10]

  always_ff @(posedge clk)
  begin
    timing_q      <= timing_src;
    timing_edge_q <= timing_src & ~timing_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmd_cnt_q      <= 3'h0;
      command_busy   <= 1'b0;
      internal_timing <= 1'b0;
    end
    else
    begin
      internal_timing <= timing_q;
      if (command_register_wr && !command_busy)
      begin
        cmd_cnt_q    <= CMD_EDGES;                            // [R11]
        command_busy <= 1'b1;
      end
      else if (command_busy && timing_edge_q)
      begin
        cmd_cnt_q    <= cmd_cnt_q - 3'h1;
        command_busy <= (cmd_cnt_q != 3'h1);                  // [R11]
      end
    end
  end

endmodule : serial_baud_clock_select
`default_nettype wire

//--- verif/baud_clock_properties.sv
// Checker: port assertions for the bit-rate clock block
`default_nettype none
module baud_clock_properties
  import baud_clock_pkg::*;
(
  input wire logic      clk,
  input wire logic      rst,
  input wire logic      oscillator_input,
  input wire logic      receive_timing_in,
  input wire logic      send_timing_in,
  input wire chan_cfg_s cfg,
  input wire logic      command_register_wr,
  input wire logic      transmit_timing_out,
  input wire logic      transmit_timing_oe_n,
  input wire logic      rx_bit_clock,
  input wire logic      tx_bit_clock,
  input wire logic      internal_timing,
  input wire logic      command_busy,
  input wire logic      sample_x16
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Assertions
  property p_take;
    command_register_wr && !command_busy |=> command_busy;
  endproperty
  a_take: assert property (p_take)
    else $error("command write not taken");
  property p_done;
    $rose(command_busy) |-> ##[1:200] !command_busy;
  endproperty
  a_done: assert property (p_done)
    else $error("command never completes");
  property p_x16;
    sample_x16 |-> cfg.format == FMT_ASYNC && cfg.async_oversample_select;
  endproperty
  a_x16: assert property (p_x16)
    else $error("oversampling outside async format");
  property p_oe;
    !transmit_timing_oe_n |->
      cfg.mode == MODE_DIV_TX_OUT && cfg.tx_out_switch;
  endproperty
  a_oe: assert property (p_oe)
    else $error("timing output driven in wrong mode");
  property p_tt;
    transmit_timing_oe_n |-> !transmit_timing_out;
  endproperty
  a_tt: assert property (p_tt)
    else $error("timing output active while released");
  property p_rt;
    cfg.mode == MODE_EXT_ONLY && $rose(receive_timing_in)
      |-> ##[1:4] rx_bit_clock;
  endproperty
  a_rt: assert property (p_rt)
    else $error("receive clock not following pin");
  property p_st;
    cfg.mode == MODE_EXT_ONLY && $rose(send_timing_in)
      |-> ##[1:4] tx_bit_clock;
  endproperty
  a_st: assert property (p_st)
    else $error("transmit clock not following pin");
  property p_byp;
    cfg.mode == MODE_DIV_TX_OUT && cfg.channel_config_second[BYPASS_BIT]
      && $rose(oscillator_input) |-> ##[1:5] $changed(tx_bit_clock);
  endproperty
  a_byp: assert property (p_byp)
    else $error("bypass clock missed a source edge");
endmodule : baud_clock_properties
bind serial_baud_clock_select baud_clock_properties u_props (
  .clk(clk), .rst(rst), .oscillator_input(oscillator_input),
  .receive_timing_in(receive_timing_in), .send_timing_in(send_timing_in),
  .cfg(cfg), .command_register_wr(command_register_wr),
  .transmit_timing_out(transmit_timing_out),
  .transmit_timing_oe_n(transmit_timing_oe_n),
  .rx_bit_clock(rx_bit_clock), .tx_bit_clock(tx_bit_clock),
  .internal_timing(internal_timing), .command_busy(command_busy),
  .sample_x16(sample_x16)
);
`default_nettype wire

//--- verif/ext_timing_model.sv
// Model: external equipment driving receive and send timing
`default_nettype none
module ext_timing_model
(
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [7:0] rt_half,
  input  wire logic [7:0] st_half,
  output var  logic       rt,
  output var  logic       st
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rc = 8'h00;
  logic [7:0] sc = 8'h00;
  // Both lines stand low outside a run; ratio stays under 1.5
  // Lines toggle steadily, with no long constant runs
  always @(negedge clk)
  begin
    rc <= (run && rc < rt_half - 8'h01) ? rc + 8'h01 : 8'h00;
    sc <= (run && sc < st_half - 8'h01) ? sc + 8'h01 : 8'h00;
    rt <= run & (rt ^ (rc == rt_half - 8'h01));
    st <= run & (st ^ (sc == st_half - 8'h01));
  end
endmodule : ext_timing_model
`default_nettype wire

//--- verif/serial_baud_clock_select_tb.sv
// Testbench: bit-rate clock selection with external timing partner
`default_nettype none
module serial_baud_clock_select_tb
  import baud_clock_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OSC_P = 6;
  logic      clk = 1'b0;
  logic      rst = 1'b1;
  logic      osc = 1'b0;
  logic      wr = 1'b0;
  logic      run = 1'b0;
  chan_cfg_s cfg = '0;
  int        oc = 0;
  int        cyc = 0;
  int        failures = 0;
  int        num_checks = 0;
  wire       rt, st, tt, oe_n, rxc, txc, itm, busy, x16;
  wire [3:0] obs = {tt, itm, rxc, txc};
  ext_timing_model u_far (.clk(clk), .run(run), .rt_half(8'h05),
    .st_half(8'h04), .rt(rt), .st(st));
  serial_baud_clock_select uut (.clk(clk), .rst(rst),
    .oscillator_input(osc), .receive_timing_in(rt), .send_timing_in(st),
    .cfg(cfg), .command_register_wr(wr), .transmit_timing_out(tt),
    .transmit_timing_oe_n(oe_n), .rx_bit_clock(rxc), .tx_bit_clock(txc),
    .internal_timing(itm), .command_busy(busy), .sample_x16(x16));
  initial forever #2 clk = !clk;
  // ==========================================================
  // Shared oscillator, period OSC_P clocks, and hang limit
  always @(negedge clk)
  begin
    oc <= (oc + 1) % 3;
    osc <= osc ^ (oc == 2);
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      failures++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic chk(input string w, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s exp %0d got %0d", w, e, g);
    end
  endtask : chk
  task automatic meas(input int s, output int per, output int hi);
    logic l;
    int r;
    l = 1'b1;
    r = 0;
    per = 0;
    hi = 0;
    for (int i = 0; i < 8000 && r < 2; i++)
    begin
      @(negedge clk);
      per += (r == 1);
      hi += (r == 1 && obs[s] === 1'b1);
      r += (obs[s] === 1'b1 && l === 1'b0);
      l = obs[s];
    end
  endtask : meas
  function automatic chan_cfg_s mk(logic [7:0] c2, c4, bd, clock_mode_e m);
    return '{c2, c4, bd, 1'b0, m, FMT_HDLC, 1'b0, 1'b1};
  endfunction : mk
  task automatic start(input chan_cfg_s c);
    rst = 1'b1;
    run = 1'b0;
    cfg = c;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    run = 1'b1;
    @(negedge clk);
  endtask : start
  // ==========================================================
  // Scenarios
  task automatic t_div;
    logic [39:0] row[8] = '{40'h20_00_00_0001, 40'h00_00_02_0006,
      40'h40_00_01_0204, 40'h00_00_40_0002, 40'hC0_00_C0_0002,
      40'h00_40_41_0004, 40'h40_40_01_0020, 40'h00_40_02_0003};
    int p, h;
    foreach (row[i])
    begin
      start(mk(row[i][39:32], row[i][31:24], row[i][23:16], MODE_DIV_TX_OUT));
      meas(0, p, h);
      chk("tx period", row[i][15:0] * OSC_P, p);
    end
    meas(0, p, h);
    chk("enhanced high", OSC_P, h);
  endtask : t_div
  task automatic t_dpll;
    chan_cfg_s c;
    int p, h;
    c = mk(8'h00, 8'h00, 8'h00, MODE_DPLL);
    for (int f = 0; f < 3; f++)
    begin
      c.format = frame_format_e'(f);
      start(c);
      meas(0, p, h);
      chk("dpll period", (f == 0 ? 2 : 32) * OSC_P, p);
    end
  endtask : t_dpll
  task automatic t_ext;
    int p, h;
    start(mk(8'h00, 8'h00, 8'h00, MODE_EXT_ONLY));
    meas(1, p, h);
    chk("rx period", 10, p);
    meas(0, p, h);
    chk("tx period", 8, p);
    start(mk(8'h00, 8'h00, 8'h01, MODE_DIV_RX_PIN));
    meas(0, p, h);
    chk("pin divided", 40, p);
  endtask : t_ext
  task automatic t_int;
    chan_cfg_s c;
    int p, h;
    c = mk(8'h00, 8'h80, 8'h04, MODE_DIV_TX_OUT);
    c.master_clock_enable = 1'b1;
    start(c);
    meas(2, p, h);
    chk("quarter master", 4 * OSC_P, p);
    c.master_clock_enable = 1'b0;
    start(c);
    meas(2, p, h);
    chk("internal tx", 10 * OSC_P, p);
  endtask : t_int
  task automatic t_cmd;
    start(mk(8'h20, 8'h00, 8'h00, MODE_DIV_TX_OUT));
    for (int k = 0; k < 3; k++)
    begin
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      chk("busy", 1, busy);
      @(negedge clk);
    end
    for (int n = 0; n < 200 && busy !== 1'b0; n++)
      @(negedge clk);
    repeat (20) @(negedge clk);
    chk("lost write", 0, busy);
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    chk("next write", 1, busy);
  endtask : t_cmd
  task automatic t_pins;
    chan_cfg_s c;
    int p, h;
    c = mk(8'h20, 8'h00, 8'h00, MODE_DIV_TX_OUT);
    c.async_oversample_select = 1'b1;
    for (int f = 0; f < 3; f++)
    begin
      c.format = frame_format_e'(f);
      start(c);
      meas(3, p, h);
      chk("tt period", OSC_P, p);
      chk("oversample", f == 0, x16);
      chk("oe", 0, oe_n);
    end
    c.tx_out_switch = 1'b0;
    start(c);
    chk("oe off", 1, oe_n);
  endtask : t_pins
  initial
  begin
    repeat (4) @(negedge clk);
    t_div();
    t_dpll();
    t_ext();
    t_int();
    t_cmd();
    t_pins();
    test_done();
  end
endmodule : serial_baud_clock_select_tb
`default_nettype wire
